// File: verilog/frame_rewrite.sv
// Frame rewrite stage: address, routing and PTP delay response rewrites
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "frame_rewrite_cfg.svh"
module frame_rewrite (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire frame_rewrite_pkg::frame_hdr_s i_hdr,
  input wire frame_rewrite_pkg::lookup_action_s i_act,
  input wire frame_rewrite_pkg::frame_ctx_s i_ctx,
  input wire frame_rewrite_pkg::domain_cfg_s i_dom_cfg [4],
  input wire logic [`RW_ADDR_W-1:0] i_addr,
  input wire logic [`RW_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`RW_DATA_W-1:0] o_rdata,
  output logic o_valid,
  output frame_rewrite_pkg::frame_hdr_s o_hdr
);
  import frame_rewrite_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [4:0] ctrl_q;
  logic [15:0] hopcfg_q;
  logic [4:0] sip_idx_q;
  logic [47:0] actsta_q;
  logic [31:0] sip_mem [`RW_SIP_ENTRIES];
  logic [15:0] conv_cnt_q;
  logic [15:0] drop_cnt_q;
  logic [`RW_DATA_W-1:0] rdata_q;
  logic valid_q;
  frame_hdr_s hdr_q;
  wire [7:0] preset_hop_value = hopcfg_q[7:0];
  wire [5:0] dest_addr_replace_bits = hopcfg_q[13:8];
  wire route_rewrite_select = ctrl_q[`RW_CTRL_RTSEL];
  wire vsi_from_egress_leg = ctrl_q[`RW_CTRL_LEG];
  wire vsi_from_egress_vid = ctrl_q[`RW_CTRL_EVID];
  wire delay_resp_global_enable = ctrl_q[`RW_CTRL_PTPEN];
  wire mc_interval_update_enable = ctrl_q[`RW_CTRL_MCUPD];

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ctrl_q <= '0;
      hopcfg_q <= '0;
      sip_idx_q <= '0;
      actsta_q <= '0;
    end else if (i_wr) begin
      case (i_addr)
        `RW_REG_CTRL: ctrl_q <= i_wdata[4:0];
        `RW_REG_HOPCFG: hopcfg_q <= i_wdata[15:0];
        `RW_REG_SIP_IDX: sip_idx_q <= i_wdata[4:0];
        `RW_REG_ACTSTA_LO: actsta_q[31:0] <= i_wdata;
        `RW_REG_ACTSTA_HI: actsta_q[47:32] <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Table is not reset; software loads it before use
  always_ff @(posedge i_core_clk) begin
    if (i_wr && i_addr == `RW_REG_SIP_DATA) begin
      sip_mem[sip_idx_q] <= i_wdata;
    end
  end

  // Unmapped indexes read as zero
  wire [`RW_DATA_W-1:0] rd_mux =
    (i_addr == `RW_REG_CTRL) ? {27'h0, ctrl_q} :
    (i_addr == `RW_REG_HOPCFG) ? {16'h0, hopcfg_q} :
    (i_addr == `RW_REG_STATUS) ? {drop_cnt_q, conv_cnt_q} :
    (i_addr == `RW_REG_SIP_IDX) ? {27'h0, sip_idx_q} :
    (i_addr == `RW_REG_SIP_DATA) ? sip_mem[sip_idx_q] :
    (i_addr == `RW_REG_ACTSTA_LO) ? actsta_q[31:0] :
    (i_addr == `RW_REG_ACTSTA_HI) ? {16'h0, actsta_q[47:32]} : '0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_rd ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // Address rewrite
  // ----------------------------------------
  // Route code shares its low bits with swap-IP; keep it out of the address modes
  wire route_code = i_act.rewrite_mode_action == `RW_MODE_ROUTE;
  wire [2:0] mode = route_code ? MODE_NONE : i_act.rewrite_mode_action[2:0];
  wire mac_sel = i_act.rewrite_mode_action[3];
  wire [47:0] station = mac_sel ? actsta_q : i_act.action_station_addr;
  wire dmac_mc = i_hdr.dmac[`RW_MAC_GROUP_BIT];
  wire dip_mc = i_hdr.is_ipv6 ? (i_hdr.dip[127:120] == `RW_V6_MC_PREFIX) :
    (i_hdr.dip[31:28] == `RW_V4_MC_PREFIX);
  wire sip_new_mc = dip_mc;
  // Four entries combine into 128 bits for IPv6; only 8 usable then
  wire [4:0] tidx = i_act.table_index_action;
  wire [2:0] tidx6 = tidx[2:0];
  wire [127:0] table_ip = i_hdr.is_ipv6 ?
    {sip_mem[{tidx6, 2'd3}], sip_mem[{tidx6, 2'd2}], sip_mem[{tidx6, 2'd1}], sip_mem[{tidx6, 2'd0}]} :
    {96'h0, sip_mem[tidx]};
  wire table_ok = !i_act.policer_enable_action;
  wire [47:0] part_mask = {48{1'b1}} << (`RW_MAC_BITS - dest_addr_replace_bits);
  wire [47:0] dmac_repl = i_act.rewrite_command_action[`RW_PARTIAL_BIT] ?
    ((station & part_mask) | (i_hdr.dmac & ~part_mask)) : station;
  wire m_swap_mac = (mode == MODE_SWAP_MAC) || (mode == MODE_SWAP_ALL);
  wire m_uc = (mode == MODE_SWAP_MAC_UC) || (mode == MODE_SWAP_ALL_UC);
  wire m_swap_ip = (mode == MODE_SWAP_ALL) || (mode == MODE_SWAP_ALL_UC) ||
    (mode == MODE_SWAP_IP) || (mode == MODE_REPL_SMAC && mac_sel);
  wire do_mac_swap = m_swap_mac || (m_uc && !dmac_mc);
  wire do_ip_swap = m_swap_ip && !(m_uc && dip_mc);
  // The MAC-only conditional mode leaves layer 3 alone
  wire do_ip_repl = (mode == MODE_SWAP_ALL_UC) && dip_mc;
  wire ip_touch = i_hdr.is_ip && (do_ip_swap || do_ip_repl);

  logic [47:0] dmac_n;
  logic [47:0] smac_n;
  logic [127:0] dip_n;
  logic [127:0] sip_n;
  always_comb begin
    dmac_n = i_hdr.dmac;
    smac_n = i_hdr.smac;
    dip_n = i_hdr.dip;
    sip_n = i_hdr.sip;
    if (mode == MODE_REPL_DMAC) begin
      dmac_n = dmac_repl;
    end else if (mode == MODE_REPL_SMAC) begin
      smac_n = station;
    end else if (do_mac_swap) begin
      dmac_n = i_hdr.smac;
      smac_n = dmac_mc ? station : i_hdr.dmac;
    end else if (m_uc) begin
      smac_n = station;
    end
    if (i_hdr.is_ip && do_ip_swap) begin
      dip_n = i_hdr.sip;
      sip_n = (sip_new_mc && table_ok) ? table_ip : i_hdr.dip;
    end else if (i_hdr.is_ip && do_ip_repl && table_ok) begin
      sip_n = table_ip;
    end
  end

  // ----------------------------------------
  // Routing and PTP
  // ----------------------------------------
  wire route = route_rewrite_select || route_code;
  wire [1:0] dom = (i_act.time_domain_select != 2'h0) ?
    i_act.time_domain_select : i_act.time_domain_select_first;
  domain_cfg_s dc;
  assign dc = i_dom_cfg[dom];
  wire [1:0] ptp_cmd = i_act.rewrite_command_action[`RW_PTP_CONV_HI:`RW_PTP_CONV_LO];
  wire conv = i_hdr.is_ptp && delay_resp_global_enable && (ptp_cmd != 2'h0);
  wire [13:0] grown = i_hdr.frame_len + `RW_GROW_BYTES;
  wire [15:0] port_num = dc.use_port_low ?
    {dc.port_number[15:`RW_LOW_PORT_BITS], i_ctx.port_number_low} : dc.port_number;
  wire [3:0] li = {i_act.exchange_addr_action, i_act.log_interval_action};

  frame_hdr_s h;
  always_comb begin
    h = i_hdr;
    h.dmac = dmac_n;
    h.smac = smac_n;
    h.dip = dip_n;
    h.sip = sip_n;
    h.fix_ip_csum = 1'b0;
    h.fix_udp_csum = 1'b0;
    h.zero_udp_csum = 1'b0;
    h.keep_dmac = 1'b0;
    h.discard = 1'b0;
    // TTL decrement for routing stays downstream
    if (ip_touch && i_act.hop_preset_enable) begin
      h.hop = preset_hop_value;
    end
    if (i_hdr.is_l4 && i_act.l4_port_replace_enable) begin
      h.sport = i_act.match_tag;
      h.dport = i_act.match_tag_mask;
    end
    if (route) begin
      h.dmac = i_ctx.next_hop_mac;
      h.keep_dmac = 1'b1;
      h.vid = i_ctx.egress_vid;
      if (vsi_from_egress_leg) begin
        h.vsi = i_ctx.egress_leg;
      end else if (vsi_from_egress_vid) begin
        h.vsi = i_ctx.egress_vid;
      end
    end
    if (conv) begin
      if (ptp_cmd == `RW_PTP_MODE_TS) begin
        h.rx_ts = i_ctx.ingress_ts;
      end
      h.msg_type = `RW_MSG_TYPE_RESP;
      h.control_field = `RW_CTRL_FIELD_RESP;
      h.msg_len = `RW_MSG_LEN_RESP;
      h.frame_len = grown;
      h.discard = grown > `RW_MAX_FRAME;
      h.flag_field = (i_hdr.flag_field & ~dc.flag_mask) | (dc.flag_value & dc.flag_mask);
      h.src_port_id = {dc.clock_id, port_num};
      h.req_port_id = i_hdr.src_port_id;
      if (dmac_mc && mc_interval_update_enable) begin
        h.log_interval = {{4{li[3]}}, li};
      end
      if (i_hdr.is_udp) begin
        h.udp_len = i_hdr.udp_len + `RW_GROW_LEN;
      end
      if (i_hdr.is_ip && !i_hdr.is_ipv6) begin
        h.ip_len = i_hdr.ip_len + `RW_GROW_LEN;
      end
    end
    if (i_hdr.is_ip && !i_hdr.is_ipv6 && (ip_touch || conv)) begin
      h.fix_ip_csum = 1'b1;
    end
    if (i_hdr.is_udp && (ip_touch || conv || i_act.l4_port_replace_enable)) begin
      h.fix_udp_csum = i_hdr.is_ipv6;
      h.zero_udp_csum = !i_hdr.is_ipv6;
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Mirror copies tap after this stage, so they carry rewrites too
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      valid_q <= 1'b0;
      hdr_q <= '0;
      conv_cnt_q <= '0;
      drop_cnt_q <= '0;
    end else begin
      valid_q <= i_valid;
      hdr_q <= h;
      if (i_valid && conv) begin
        conv_cnt_q <= conv_cnt_q + 16'h0001;
      end
      if (i_valid && h.discard) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
    end
  end

  assign o_valid = valid_q;
  assign o_hdr = hdr_q;
  assign o_rdata = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_conv_in;
    i_valid && conv;
  endsequence
  sequence s_route_in;
    i_valid && route;
  endsequence

  a_resp_type: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && conv) |=> (o_hdr.msg_type == `RW_MSG_TYPE_RESP && o_hdr.control_field == `RW_CTRL_FIELD_RESP))
    else $error("response type not set");
  a_resp_len: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && conv) |=> (o_hdr.msg_len == `RW_MSG_LEN_RESP && o_hdr.frame_len == $past(grown)))
    else $error("length not grown");
  a_drop_big: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && conv && grown > `RW_MAX_FRAME) |=> o_hdr.discard)
    else $error("oversize not discarded");
  a_no_conv: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && !delay_resp_global_enable) |=> (o_hdr.msg_type == $past(i_hdr.msg_type)))
    else $error("converted while disabled");
  a_route_dmac: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && route) |=> (o_hdr.keep_dmac && o_hdr.dmac == $past(i_ctx.next_hop_mac)))
    else $error("route dmac wrong");
  a_route_vid: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && route) |=> (o_hdr.vid == $past(i_ctx.egress_vid)))
    else $error("egress vid missing");
  a_zero_mode: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && i_act.rewrite_mode_action == 4'h0 && !route_rewrite_select) |=>
    (o_hdr.smac == $past(i_hdr.smac) && o_hdr.dmac == $past(i_hdr.dmac)))
    else $error("addresses changed in mode zero");
  a_req_port: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && conv) |=> (o_hdr.req_port_id == $past(i_hdr.src_port_id)))
    else $error("requesting identity wrong");
  a_l4_ports: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && i_hdr.is_l4 && i_act.l4_port_replace_enable) |=> (o_hdr.sport == $past(i_act.match_tag)))
    else $error("port not replaced");
  a_v4_udp_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && conv && i_hdr.is_udp && !i_hdr.is_ipv6) |=> o_hdr.zero_udp_csum)
    else $error("udp checksum not zeroed");
  a_v4_ip_csum: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 (i_hdr.is_ip && !i_hdr.is_ipv6) |=> o_hdr.fix_ip_csum)
    else $error("ip checksum fix not flagged");
  a_ts_load: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 (ptp_cmd == `RW_PTP_MODE_TS) |=> (o_hdr.rx_ts == $past(i_ctx.ingress_ts)))
    else $error("receive stamp not loaded");
  a_ts_keep: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 (ptp_cmd != `RW_PTP_MODE_TS) |=> (o_hdr.rx_ts == $past(i_hdr.rx_ts)))
    else $error("receive stamp changed");
  a_udp_grow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 i_hdr.is_udp |=> (o_hdr.udp_len == $past(i_hdr.udp_len) + `RW_GROW_LEN))
    else $error("udp length not grown");
  a_v4_len_grow: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 (i_hdr.is_ip && !i_hdr.is_ipv6) |=> (o_hdr.ip_len == $past(i_hdr.ip_len) + `RW_GROW_LEN))
    else $error("ip length not grown");
  a_mc_interval: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_conv_in ##0 (dmac_mc && mc_interval_update_enable) |=>
    (o_hdr.log_interval[7:3] == 5'h00 || o_hdr.log_interval[7:3] == 5'h1F))
    else $error("log interval out of range");
  a_route_hop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_route_in ##0 !ip_touch |=> (o_hdr.hop == $past(i_hdr.hop)))
    else $error("hop changed by routing");
  a_keep_dmac_off: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && !route) |=> !o_hdr.keep_dmac)
    else $error("keep flag without routing");
  a_hop_preset: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && ip_touch && i_act.hop_preset_enable) |=> (o_hdr.hop == $past(preset_hop_value)))
    else $error("hop not preset");
  a_uc_ip_keep: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && mode == MODE_SWAP_MAC_UC) |=> (o_hdr.sip == $past(i_hdr.sip) && o_hdr.dip == $past(i_hdr.dip)))
    else $error("ip changed in mac-only mode");
  a_swap_mac: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && mode == MODE_SWAP_MAC && !route) |=> (o_hdr.dmac == $past(i_hdr.smac)))
    else $error("mac not swapped");
  a_smac_repl: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    (i_valid && mode == MODE_REPL_SMAC) |=> (o_hdr.smac == $past(station)))
    else $error("smac not replaced");
endmodule
`default_nettype wire

// File: verilog/frame_rewrite_cfg.svh
// Constants for the frame rewrite stage
`ifndef FRAME_REWRITE_CFG_SVH
`define FRAME_REWRITE_CFG_SVH
`define RW_ADDR_W 5
`define RW_DATA_W 32
`define RW_REG_CTRL 5'h00
`define RW_REG_HOPCFG 5'h01
`define RW_REG_STATUS 5'h02
`define RW_REG_SIP_IDX 5'h03
`define RW_REG_SIP_DATA 5'h04
`define RW_REG_ACTSTA_LO 5'h05
`define RW_REG_ACTSTA_HI 5'h06
`define RW_CTRL_RTSEL 0
`define RW_CTRL_LEG 1
`define RW_CTRL_EVID 2
`define RW_CTRL_PTPEN 3
`define RW_CTRL_MCUPD 4
`define RW_PARTIAL_BIT 9
`define RW_PTP_MODE_TS 1
`define RW_PTP_MODE_NOTS 2
`define RW_PTP_CONV_LO 0
`define RW_PTP_CONV_HI 1
`define RW_MSG_TYPE_RESP 4'h9
`define RW_CTRL_FIELD_RESP 8'h03
`define RW_MSG_LEN_RESP 16'h0054
`define RW_GROW_BYTES 14'h000A
`define RW_MAX_FRAME 14'h0094
`define RW_UDP_LEN_REQ 16'h002C
`define RW_SIP_ENTRIES 32
`define RW_LOW_PORT_BITS 6
`define RW_GROW_LEN 16'h000A
`define RW_MODE_ROUTE 4'hF
`define RW_MAC_GROUP_BIT 40
`define RW_MAC_BITS 6'h30
`define RW_V6_MC_PREFIX 8'hFF
`define RW_V4_MC_PREFIX 4'hE
`endif

// File: verilog/frame_rewrite_pkg.sv
// Types for the frame rewrite stage
package frame_rewrite_pkg;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_REPL_DMAC, MODE_REPL_SMAC, MODE_SWAP_MAC, MODE_SWAP_MAC_UC,
    MODE_SWAP_ALL, MODE_SWAP_ALL_UC, MODE_SWAP_IP
  } rewrite_mode_e;
  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic is_ipv6;
    logic is_ip;
    logic is_udp;
    logic is_l4;
    logic is_ptp;
    logic [127:0] dip;
    logic [127:0] sip;
    logic [7:0] hop;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [15:0] ip_len;
    logic [15:0] udp_len;
    logic [13:0] frame_len;
    logic [3:0] msg_type;
    logic [15:0] msg_len;
    logic [15:0] flag_field;
    logic [79:0] src_port_id;
    logic [79:0] req_port_id;
    logic [7:0] control_field;
    logic [7:0] log_interval;
    logic [79:0] rx_ts;
    logic [11:0] vid;
    logic [11:0] vsi;
    logic keep_dmac;
    logic fix_ip_csum;
    logic fix_udp_csum;
    logic zero_udp_csum;
    logic discard;
  } frame_hdr_s;
  typedef struct packed {
    logic [3:0] rewrite_mode_action;
    logic [47:0] action_station_addr;
    logic [9:0] rewrite_command_action;
    logic [4:0] table_index_action;
    logic policer_enable_action;
    logic hop_preset_enable;
    logic l4_port_replace_enable;
    logic [15:0] match_tag;
    logic [15:0] match_tag_mask;
    logic exchange_addr_action;
    logic [2:0] log_interval_action;
    logic [1:0] time_domain_select_first;
    logic [1:0] time_domain_select;
  } lookup_action_s;
  typedef struct packed {
    logic [1:0] port_time_domain;
    logic [5:0] port_number_low;
    logic [47:0] next_hop_mac;
    logic [11:0] egress_vid;
    logic [11:0] egress_leg;
    logic [79:0] ingress_ts;
  } frame_ctx_s;
  typedef struct packed {
    logic [63:0] clock_id;
    logic [15:0] port_number;
    logic use_port_low;
    logic [15:0] flag_value;
    logic [15:0] flag_mask;
  } domain_cfg_s;
endpackage

// File: test/rewrite_sink.sv
// Downstream rewriter model: collects each rewritten header
`timescale 1ns/100ps
`default_nettype none
module rewrite_sink (
  input wire logic i_core_clk,
  input wire logic i_valid,
  input wire frame_rewrite_pkg::frame_hdr_s i_hdr
);
  import frame_rewrite_pkg::*;
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Hop decrement is not modelled here; the stage itself only presets the hop, when enabled, for IP frames that select an IP swap or source replace
  frame_hdr_s got_q[$];
  always @(posedge i_core_clk) begin
    if (i_valid === 1'b1) begin
      got_q.push_back(i_hdr);
    end
  end
endmodule
`default_nettype wire

// File: test/frame_rewrite_tb.sv
// Self-checking bench for the frame rewrite stage
`timescale 1ns/100ps
`default_nettype none
`include "frame_rewrite_cfg.svh"
module frame_rewrite_tb;
  import frame_rewrite_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [47:0] STA = 48'h4567_89AB_CDEF;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_valid = 1'b0;
  frame_hdr_s i_hdr = '0;
  lookup_action_s i_act = '0;
  frame_ctx_s i_ctx = '0;
  domain_cfg_s i_dom_cfg [4];
  logic [`RW_ADDR_W-1:0] i_addr = '0;
  logic [`RW_DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [`RW_DATA_W-1:0] o_rdata;
  logic o_valid;
  frame_hdr_s o_hdr;
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h7868A40A;
  frame_hdr_s h;
  frame_hdr_s g;
  frame_hdr_s e;
  lookup_action_s a;
  logic [`RW_DATA_W-1:0] d;
  logic [127:0] q0;
  logic [127:0] q1;
  logic [15:0] fm;
  always #5 i_core_clk = ~i_core_clk;
  frame_rewrite frame_rewrite_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_valid(i_valid),
    .i_hdr(i_hdr), .i_act(i_act), .i_ctx(i_ctx), .i_dom_cfg(i_dom_cfg), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_valid(o_valid), .o_hdr(o_hdr));
  rewrite_sink rewrite_sink_inst (.i_core_clk(i_core_clk), .i_valid(o_valid), .i_hdr(o_hdr));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic roll();
    q0 = {$random(seed), $random(seed), $random(seed), $random(seed)};
    q1 = {$random(seed), $random(seed), $random(seed), $random(seed)};
  endtask
  task automatic wr(input logic [`RW_ADDR_W-1:0] ad, input logic [`RW_DATA_W-1:0] wd);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= wd;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [`RW_ADDR_W-1:0] ad);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic send(input frame_hdr_s hd, input lookup_action_s ac);
    int k;
    @(posedge i_core_clk);
    i_valid <= 1'b1;
    i_hdr <= hd;
    i_act <= ac;
    @(posedge i_core_clk);
    i_valid <= 1'b0;
    k = 0;
    while (rewrite_sink_inst.got_q.size() == 0 && k < 8) begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    if (rewrite_sink_inst.got_q.size() == 0) begin
      n_fail++;
      $display("CHECK FAILED output valid expected 1 seen 0");
      report_and_stop();
    end
    g = rewrite_sink_inst.got_q.pop_front();
  endtask
  // Address rewrite reference; unicast IPs keep the table out of play
  function automatic frame_hdr_s model(input frame_hdr_s hd, input lookup_action_s ac);
    frame_hdr_s x;
    logic mc;
    int m;
    x = hd;
    mc = hd.dmac[40];
    m = ac.rewrite_mode_action;
    if (m == 1) x.dmac = ac.action_station_addr;
    if (m == 2) x.smac = ac.action_station_addr;
    if (m == 10) x.smac = STA;
    if (m >= 3 && m <= 6) begin
      x.smac = mc ? ac.action_station_addr : hd.dmac;
      if (!(mc && m[0] == 1'b0)) x.dmac = hd.smac;
    end
    if (m >= 5) begin
      x.sip = hd.dip;
      x.dip = hd.sip;
      x.hop = 8'h33;
    end
    if (ac.l4_port_replace_enable && hd.is_l4) begin
      x.sport = ac.match_tag;
      x.dport = ac.match_tag_mask;
    end
    return x;
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int k = 0; k < 4; k++) begin
      roll();
      i_dom_cfg[k] = q0[112:0];
      i_dom_cfg[k].use_port_low = (k == 1);
    end
    roll();
    i_ctx = {q0[79:0], q1[79:0]};
    i_ctx.port_time_domain = 2'h1;
    repeat (4) @(posedge i_core_clk);
    #1;
    chk("valid in reset", 0, o_valid);
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd(`RW_REG_CTRL);
    chk("ctrl reset", 0, d);
    rd(5'h1F);
    chk("unmapped read", 0, d);
    wr(`RW_REG_HOPCFG, 32'h0000_0033);
    wr(`RW_REG_ACTSTA_LO, STA[31:0]);
    wr(`RW_REG_ACTSTA_HI, {16'h0000, STA[47:32]});
    rd(`RW_REG_HOPCFG);
    chk("hop config", 32'h0000_0033, d);
    $display("Test registers done");
    for (int m = 0; m < 9; m++) begin
      for (int r = 0; r < 2; r++) begin
        roll();
        h = '0;
        h.dmac = {q0[47:41], r[0], q0[39:0]};
        h.smac = q1[47:0];
        h.is_ip = 1'b1;
        h.is_ipv6 = 1'b1;
        h.is_l4 = 1'b1;
        h.dip = {8'h20, q0[119:0]};
        h.sip = {8'h20, q1[119:0]};
        h.hop = 8'h11;
        a = '0;
        a.rewrite_mode_action = (m == 8) ? 4'hA : 4'(m);
        a.action_station_addr = q1[95:48];
        a.hop_preset_enable = 1'b1;
        a.l4_port_replace_enable = 1'b1;
        a.match_tag = q0[127:112];
        a.match_tag_mask = q1[127:112];
        send(h, a);
        e = model(h, a);
        chk("dmac", e.dmac, g.dmac);
        chk("smac", e.smac, g.smac);
        chk("sip", e.sip, g.sip);
        chk("dip", e.dip, g.dip);
        chk("hop", e.hop, g.hop);
        chk("ports", {e.sport, e.dport}, {g.sport, g.dport});
      end
    end
    $display("Test address modes done");
    wr(`RW_REG_CTRL, 32'h0000_0003);
    roll();
    h = '0;
    h.dmac = q0[47:0];
    h.hop = 8'h40;
    h.vid = q1[11:0];
    a = '0;
    send(h, a);
    chk("route dmac", i_ctx.next_hop_mac, g.dmac);
    chk("keep dmac", 1, g.keep_dmac);
    chk("route vid", i_ctx.egress_vid, g.vid);
    chk("route vsi", i_ctx.egress_leg, g.vsi);
    chk("route hop", 8'h40, g.hop);
    wr(`RW_REG_CTRL, 32'h0000_0000);
    h.is_ip = 1'b1;
    h.dip = q0;
    h.sip = q1;
    a.rewrite_mode_action = `RW_MODE_ROUTE;
    send(h, a);
    chk("code route dmac", i_ctx.next_hop_mac, g.dmac);
    chk("code route smac", h.smac, g.smac);
    chk("code route sip", h.sip, g.sip);
    chk("code route vsi", h.vsi, g.vsi);
    $display("Test route rewrite done");
    wr(`RW_REG_SIP_IDX, 32'h0000_0003);
    wr(`RW_REG_SIP_DATA, 32'hC0A8_0105);
    wr(`RW_REG_HOPCFG, 32'h0000_1833);
    for (int m = 3; m < 8; m++) begin
      h = '0;
      h.dmac = 48'h0200_0000_0011;
      h.smac = 48'h0200_0000_0022;
      h.is_ip = 1'b1;
      h.dip = 128'hE000_0001;
      h.sip = 128'h0A00_0002;
      a = '0;
      a.rewrite_mode_action = (m == 3) ? 4'h1 : 4'(m);
      a.rewrite_command_action = 10'h200;
      a.action_station_addr = STA;
      a.table_index_action = 5'h03;
      a.hop_preset_enable = 1'b1;
      send(h, a);
      chk("part dmac", (m == 3) ? {STA[47:24], h.dmac[23:0]} : (m == 7) ? h.dmac : h.smac, g.dmac);
      chk("table smac", (m == 3 || m == 7) ? h.smac : h.dmac, g.smac);
      chk("table sip", (m < 5) ? h.sip : 128'hC0A8_0105, g.sip);
      chk("table dip", (m == 5 || m == 7) ? h.sip : h.dip, g.dip);
      chk("table hop", (m < 5) ? 8'h00 : 8'h33, g.hop);
      chk("ip csum", m >= 5, g.fix_ip_csum);
    end
    $display("Test source table done");
    for (int c = 0; c < 3; c++) begin
      wr(`RW_REG_CTRL, (c == 0) ? 32'h0000_0000 : 32'h0000_0018);
      roll();
      h = '0;
      h.dmac = 48'h0100_0000_0000;
      h.is_ptp = 1'b1;
      h.is_udp = 1'b1;
      h.is_ip = 1'b1;
      h.udp_len = `RW_UDP_LEN_REQ;
      h.ip_len = 16'h0040;
      h.frame_len = (c == 2) ? 14'd139 : 14'd90;
      h.msg_type = 4'h1;
      h.control_field = 8'h01;
      h.flag_field = q0[15:0];
      h.src_port_id = q0[95:16];
      h.rx_ts = q1[79:0];
      a = '0;
      a.rewrite_command_action = (c == 2) ? 10'h002 : 10'h001;
      a.time_domain_select_first = 2'h2;
      a.time_domain_select = 2'h1;
      a.exchange_addr_action = 1'b1;
      a.log_interval_action = 3'h5;
      send(h, a);
      fm = i_dom_cfg[1].flag_mask;
      chk("msg type", (c == 0) ? 4'h1 : 4'h9, g.msg_type);
      chk("rx stamp", (c == 1) ? i_ctx.ingress_ts : h.rx_ts, g.rx_ts);
      chk("discard", c == 2, g.discard);
      if (c == 1) begin
        chk("control", 8'h03, g.control_field);
        chk("msg len", 16'h0054, g.msg_len);
        chk("frame len", 14'd100, g.frame_len);
        chk("lengths", {16'h0036, 16'h004A}, {g.udp_len, g.ip_len});
        chk("req id", h.src_port_id, g.req_port_id);
        chk("src id", {i_dom_cfg[1].clock_id, i_dom_cfg[1].port_number[15:6], i_ctx.port_number_low},
          g.src_port_id);
        chk("flags", (h.flag_field & ~fm) | (i_dom_cfg[1].flag_value & fm), g.flag_field);
        chk("udp csum zero", 1, g.zero_udp_csum);
        chk("ip csum fix", 1, g.fix_ip_csum);
        chk("log interval", 8'hFD, g.log_interval);
      end
    end
    rd(`RW_REG_STATUS);
    chk("discard count", 16'h0001, d[31:16]);
    chk("conversion count", 16'h0002, d[15:0]);
    $display("Test delay response done");
    report_and_stop();
  end
endmodule
`default_nettype wire
